// [common/tec_pkg.sv]
// shared constants, carriers and helpers for the timer/event counter channel
// Function
// - interval, event, software and triggered pulse modes
// - counter, buffered compares, captures, toggling flip-flop
// - capture gives triggered one-shot and width measurement
// - one channel per instance, its pins and events chosen by parameter
// - pins only where the channel has them
// - match, capture and conversion-start events per channel
// - unit disabled blocks all other register access
// - disabling keeps every register setting
// - debug halt stops channel when stop bit set
// - stopped counter reads last running snapshot
// - twelve word registers from channel base address
// - control holds buffer, idle, edge, start source
// - flags set unmasked, cleared by status read
// - clear enable zeroes counter on second match
// - source select picks pin or prescaler tap
package tec_pkg;

  localparam int unsigned TEC_DW = 16;
  localparam logic [31:0] TEC_CH0_BASE = 32'h4001_0000;
  localparam int unsigned TEC_WIN_LSB = 6;

  // register offsets inside a channel window
  localparam logic [5:0] OFS_EN = 6'h00;
  localparam logic [5:0] OFS_RUN = 6'h04;
  localparam logic [5:0] OFS_CR = 6'h08;
  localparam logic [5:0] OFS_MOD = 6'h0C;
  localparam logic [5:0] OFS_FFCR = 6'h10;
  localparam logic [5:0] OFS_ST = 6'h14;
  localparam logic [5:0] OFS_IM = 6'h18;
  localparam logic [5:0] OFS_UC = 6'h1C;
  localparam logic [5:0] OFS_RG0 = 6'h20;
  localparam logic [5:0] OFS_RG1 = 6'h24;
  localparam logic [5:0] OFS_CP0 = 6'h28;
  localparam logic [5:0] OFS_CP1 = 6'h2C;

  // field positions
  localparam int unsigned EN_ENABLE_BIT = 7;
  localparam int unsigned EN_HALT_BIT = 6;
  localparam int unsigned RUN_PRUN_BIT = 2;
  localparam int unsigned RUN_RUN_BIT = 0;
  localparam int unsigned CR_WBF_BIT = 7;
  localparam int unsigned CR_IDLE_BIT = 3;
  localparam int unsigned CR_TRG_BIT = 1;
  localparam int unsigned CR_START_SOURCE_SELECT_BIT = 0;
  localparam int unsigned MOD_RSWR_BIT = 7;
  localparam int unsigned MOD_SWCAP_BIT = 6;
  localparam int unsigned MOD_CPM_LSB = 4;
  localparam int unsigned MOD_CLE_BIT = 3;
  localparam int unsigned MOD_CLK_LSB = 0;
  localparam int unsigned FF_TRIG_LSB = 2;
  localparam int unsigned FF_CTL_LSB = 0;
  localparam int unsigned ST_OF_BIT = 2;
  localparam int unsigned ST_M1_BIT = 1;
  localparam int unsigned ST_M0_BIT = 0;

  // fixed readback and reset values
  localparam logic [31:0] FFCR_FIXED = 32'h0000_00C3;
  localparam logic [3:0] FF_TRIG_RST = 4'h0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // capture timing, flip-flop control and source codes
  localparam logic [1:0] CPM_OFF = 2'h0;
  localparam logic [1:0] CPM_EXT_RISE = 2'h1;
  localparam logic [1:0] CPM_EXT_BOTH = 2'h2;
  localparam logic [1:0] CPM_INT_BOTH = 2'h3;
  localparam logic [1:0] FFC_INVERT = 2'h0;
  localparam logic [1:0] FFC_SET = 2'h1;
  localparam logic [1:0] FFC_CLEAR = 2'h2;
  localparam logic [1:0] FFC_KEEP = 2'h3;
  localparam logic [2:0] CLK_EXT = 3'h0;

  typedef enum logic [1:0] {RUN_STOP, RUN_WAIT, RUN_COUNT} tec_run_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tec_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tec_wb_rsp_t;

  typedef struct packed {
    logic match_interrupt_a;
    logic match_interrupt_b;
    logic overflow_interrupt;
    logic capture_interrupt_a;
    logic capture_interrupt_b;
  } tec_irq_t;

  // byte-lane merge of a write into the current register image
  function automatic logic [31:0] tec_merge(input logic [31:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[i*8 +: 8] = wdat[i*8 +: 8];
    end
    return res;
  endfunction

  // log2 of the prescaler divisor for each source code
  function automatic logic [3:0] tec_tap_shift(input logic [2:0] sel);
    logic [3:0] sh;
    unique case (sel)
      3'h0: sh = 4'h0;
      3'h1: sh = 4'h0;
      3'h2: sh = 4'h2;
      3'h3: sh = 4'h4;
      3'h4: sh = 4'h5;
      3'h5: sh = 4'h6;
      3'h6: sh = 4'h7;
      3'h7: sh = 4'h8;
    endcase
    return sh;
  endfunction

endpackage

// [hdl/tec_prescaler.sv]
// prescaler with selectable divide taps for one timer channel
`timescale 1ns/10ps
module tec_prescaler #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic freeze_i,
  input wire logic [2:0] tap_i,
  output logic tick_o
);
  import tec_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } tec_psc_t;

  tec_psc_t s_q;
  tec_psc_t s_d;
  logic [WIDTH-1:0] mask;

  // a tap fires when its low counter bits are all ones
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    mask = WIDTH'((32'd1 << tec_tap_shift(tap_i)) - 32'd1);
    if (!run_i)
      s_d.count = '0;
    else if (!freeze_i)
    begin
      s_d.tick = (s_q.count & mask) == mask;
      s_d.count = s_q.count + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_o = s_q.tick;
endmodule

// [hdl/tec_channel.sv]
// one 16-bit timer/event counter channel with its classic wishbone register slave
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module tec_channel #(
  parameter logic [31:0] BASE_ADDR = tec_pkg::TEC_CH0_BASE,
  parameter bit HAS_EXT_INPUT = 1'b0,
  parameter bit HAS_FF_OUTPUT = 1'b0,
  parameter bit HAS_CAPTURE_IRQ = 1'b1,
  parameter bit HAS_INT_PULSE = 1'b1,
  parameter bit HAS_ADC_START = 1'b0,
  parameter int unsigned PSC_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input tec_pkg::tec_wb_req_t wb_i,
  output tec_pkg::tec_wb_rsp_t wb_o,
  input wire logic ch_external_input_i,
  input wire logic internal_pulse_source_i,
  input wire logic debug_halt_i,
  input wire logic idle_mode_i,
  output tec_pkg::tec_irq_t irq_o,
  output logic ch5_match1_event_o,
  output logic ch7_flipflop_output_o
);
  import tec_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic unit_enable;
    logic debug_halt_stop;
    logic prescaler_run;
    logic count_run;
    logic double_buffer_enable;
    logic idle_operation;
    logic trigger_edge_select;
    logic start_source_select;
    logic rswr;
    logic [1:0] cpm;
    logic counter_clear_enable;
    logic [2:0] source_clock_select;
    logic [3:0] ff_trig;
    logic [2:0] flags;
    logic [2:0] mask;
    logic [TEC_DW-1:0] cnt;
    logic [TEC_DW-1:0] snap;
    logic [TEC_DW-1:0] rg0;
    logic [TEC_DW-1:0] rg1;
    logic [TEC_DW-1:0] buf0;
    logic [TEC_DW-1:0] buf1;
    logic wr0;
    logic wr1;
    logic [TEC_DW-1:0] cp0;
    logic [TEC_DW-1:0] cp1;
    logic ff;
    tec_run_t run_st;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ipl_prev;
    tec_irq_t irq;
    logic adc;
  } tec_state_t;

  tec_state_t s_q;
  tec_state_t s_d;
  logic psc_tick;
  logic live;
  logic req;
  logic hit;
  logic wr;
  logic rd;
  logic [5:0] ofs;
  logic [31:0] rv;
  logic [31:0] nv;
  logic ext_rise;
  logic ext_fall;
  logic ipl_rise;
  logic ipl_fall;
  logic trig_edge;
  logic src;
  logic inc;
  logic m0;
  logic m1;
  logic ovf;
  logic cap0;
  logic cap1;
  logic tog;

  // the prescaler freezes with the channel so halts and idle stop every tap
  tec_prescaler #(
    .WIDTH(PSC_WIDTH)
  ) u_psc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(s_q.prescaler_run & s_q.unit_enable),
    .freeze_i(~live),
    .tap_i(s_q.source_clock_select),
    .tick_o(psc_tick)
  );

  // whole channel next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.irq = '0;
    s_d.adc = 1'b0;

    s_d.ext_s1 = HAS_EXT_INPUT ? ch_external_input_i : 1'b0;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    s_d.ipl_prev = internal_pulse_source_i;
    ext_rise = s_q.ext_s2 & ~s_q.ext_s3;
    ext_fall = ~s_q.ext_s2 & s_q.ext_s3;
    ipl_rise = HAS_INT_PULSE & internal_pulse_source_i & ~s_q.ipl_prev;
    ipl_fall = HAS_INT_PULSE & ~internal_pulse_source_i & s_q.ipl_prev;

    live = s_q.unit_enable & ~(debug_halt_i & s_q.debug_halt_stop)
           & ~(idle_mode_i & ~s_q.idle_operation);

    req = wb_i.cyc & wb_i.stb & ~s_q.ack;
    hit = wb_i.adr[31:TEC_WIN_LSB] == BASE_ADDR[31:TEC_WIN_LSB];
    ofs = wb_i.adr[TEC_WIN_LSB-1:0];
    wr = req & wb_i.we & hit;
    rd = req & ~wb_i.we & hit;

    // read image; blocks reads except the enable word when disabled; unused bits zero
    rv = '0;
    if (hit && (ofs == OFS_EN || s_q.unit_enable))
    begin
      case (ofs)
        OFS_EN:
        begin
          rv[EN_ENABLE_BIT] = s_q.unit_enable;
          rv[EN_HALT_BIT] = s_q.debug_halt_stop;
        end
        OFS_RUN:
        begin
          rv[RUN_PRUN_BIT] = s_q.prescaler_run;
          rv[RUN_RUN_BIT] = s_q.count_run;
        end
        OFS_CR:
        begin
          rv[CR_WBF_BIT] = s_q.double_buffer_enable;
          rv[CR_IDLE_BIT] = s_q.idle_operation;
          rv[CR_TRG_BIT] = s_q.trigger_edge_select;
          rv[CR_START_SOURCE_SELECT_BIT] = s_q.start_source_select;
        end
        OFS_MOD:
        begin
          rv[MOD_RSWR_BIT] = s_q.rswr;
          rv[MOD_SWCAP_BIT] = 1'b1;
          rv[MOD_CPM_LSB +: 2] = s_q.cpm;
          rv[MOD_CLE_BIT] = s_q.counter_clear_enable;
          rv[MOD_CLK_LSB +: 3] = s_q.source_clock_select;
        end
        OFS_FFCR:
        begin
          rv = FFCR_FIXED;
          rv[FF_TRIG_LSB +: 4] = s_q.ff_trig;
        end
        OFS_ST: rv[2:0] = s_q.flags;
        OFS_IM: rv[2:0] = s_q.mask;
        OFS_UC: rv[TEC_DW-1:0] = s_q.count_run ? s_q.cnt : s_q.snap;
        OFS_RG0: rv[TEC_DW-1:0] = s_q.buf0;
        OFS_RG1: rv[TEC_DW-1:0] = s_q.buf1;
        OFS_CP0: rv[TEC_DW-1:0] = s_q.cp0;
        OFS_CP1: rv[TEC_DW-1:0] = s_q.cp1;
        default: rv = '0;
      endcase
    end
    nv = tec_merge(rv, wb_i.dat, wb_i.sel);

    // one-cycle answer to every request, foreign addresses included
    if (req)
    begin
      s_d.ack = 1'b1;
      s_d.rdat = rd ? rv : '0;
    end

    // wait for trigger edge; software or triggered start
    trig_edge = s_q.trigger_edge_select ? ext_fall : ext_rise;
    unique case (s_q.run_st)
      RUN_STOP:
      begin
        if (s_q.count_run)
          s_d.run_st = s_q.start_source_select ? RUN_WAIT : RUN_COUNT;
      end
      RUN_WAIT:
      begin
        if (trig_edge && live)
          s_d.run_st = RUN_COUNT;
      end
      RUN_COUNT: s_d.run_st = RUN_COUNT;
    endcase
    if (!s_q.count_run)
      s_d.run_st = RUN_STOP;

    src = (s_q.source_clock_select == CLK_EXT) ? ext_rise : psc_tick;
    inc = live & (s_q.run_st == RUN_COUNT) & src;
    m0 = inc & (s_q.cnt == s_q.rg0);
    m1 = inc & (s_q.cnt == s_q.rg1);
    ovf = inc & (s_q.cnt == CNT_MAX);

    // counter stop clears; step and wrap; clear on match
    if (!s_q.count_run)
      s_d.cnt = '0;
    else if (inc)
      s_d.cnt = (m1 & s_q.counter_clear_enable) ? '0 : s_q.cnt + 1'b1;
    if (s_q.count_run)
      s_d.snap = s_q.cnt;

    // buffered compare transfer at the second match
    if (s_q.double_buffer_enable && m1 && (!s_q.rswr || (s_q.wr0 && s_q.wr1)))
    begin
      s_d.rg0 = s_q.buf0;
      s_d.rg1 = s_q.buf1;
      s_d.wr0 = 1'b0;
      s_d.wr1 = 1'b0;
    end

    // capture on pin or internal pulse edges
    cap0 = 1'b0;
    cap1 = 1'b0;
    unique case (s_q.cpm)
      CPM_OFF: cap0 = 1'b0;
      CPM_EXT_RISE: cap0 = ext_rise;
      CPM_EXT_BOTH:
      begin
        cap0 = ext_rise;
        cap1 = ext_fall;
      end
      CPM_INT_BOTH:
      begin
        cap0 = ipl_rise;
        cap1 = ipl_fall;
      end
    endcase
    cap0 = cap0 & live;
    cap1 = cap1 & live;
    // software capture strobe when the mode bit is written low
    if (wr && ofs == OFS_MOD && s_q.unit_enable && wb_i.sel[0] && !wb_i.dat[MOD_SWCAP_BIT])
      cap0 = 1'b1;
    if (cap0)
      s_d.cp0 = s_q.cnt;
    if (cap1)
      s_d.cp1 = s_q.cnt;

    tog = (m0 & s_q.ff_trig[0]) | (m1 & s_q.ff_trig[1])
          | (cap0 & s_q.ff_trig[2]) | (cap1 & s_q.ff_trig[3]);
    if (tog)
      s_d.ff = ~s_q.ff;

    // set regardless of mask, read clears, set wins
    s_d.flags = s_q.flags;
    if (rd && ofs == OFS_ST && s_q.unit_enable)
      s_d.flags = '0;
    s_d.flags[ST_M0_BIT] = s_d.flags[ST_M0_BIT] | m0;
    s_d.flags[ST_M1_BIT] = s_d.flags[ST_M1_BIT] | m1;
    s_d.flags[ST_OF_BIT] = s_d.flags[ST_OF_BIT] | ovf;

    // masked match and overflow pulses, unmasked captures and conversion start
    s_d.irq.match_interrupt_a = m0 & s_q.mask[ST_M0_BIT];
    s_d.irq.match_interrupt_b = m1 & s_q.mask[ST_M1_BIT];
    s_d.irq.overflow_interrupt = ovf & s_q.mask[ST_OF_BIT];
    s_d.irq.capture_interrupt_a = HAS_CAPTURE_IRQ & cap0;
    s_d.irq.capture_interrupt_b = HAS_CAPTURE_IRQ & cap1;
    s_d.adc = HAS_ADC_START & m1;

    // register writes; only the enable register while disabled
    if (wr && ofs == OFS_EN)
    begin
      s_d.unit_enable = nv[EN_ENABLE_BIT];
      s_d.debug_halt_stop = nv[EN_HALT_BIT];
    end
    else if (wr && s_q.unit_enable)
    begin
      case (ofs)
        OFS_RUN:
        begin
          s_d.prescaler_run = nv[RUN_PRUN_BIT];
          s_d.count_run = nv[RUN_RUN_BIT];
        end
        OFS_CR:
        begin
          s_d.double_buffer_enable = nv[CR_WBF_BIT];
          s_d.idle_operation = nv[CR_IDLE_BIT];
          s_d.trigger_edge_select = nv[CR_TRG_BIT];
          s_d.start_source_select = nv[CR_START_SOURCE_SELECT_BIT];
        end
        OFS_MOD:
        begin
          s_d.rswr = nv[MOD_RSWR_BIT];
          s_d.cpm = nv[MOD_CPM_LSB +: 2];
          s_d.counter_clear_enable = nv[MOD_CLE_BIT];
          s_d.source_clock_select = nv[MOD_CLK_LSB +: 3];
        end
        OFS_FFCR:
        begin
          s_d.ff_trig = nv[FF_TRIG_LSB +: 4];
          unique case (nv[FF_CTL_LSB +: 2])
            FFC_INVERT: s_d.ff = ~s_q.ff;
            FFC_SET: s_d.ff = 1'b1;
            FFC_CLEAR: s_d.ff = 1'b0;
            FFC_KEEP: s_d.ff = s_d.ff;
          endcase
        end
        OFS_IM: s_d.mask = nv[2:0];
        OFS_RG0:
        begin
          s_d.buf0 = nv[TEC_DW-1:0];
          s_d.wr0 = 1'b1;
          if (!s_q.double_buffer_enable)
            s_d.rg0 = nv[TEC_DW-1:0];
        end
        OFS_RG1:
        begin
          s_d.buf1 = nv[TEC_DW-1:0];
          s_d.wr1 = 1'b1;
          if (!s_q.double_buffer_enable)
            s_d.rg1 = nv[TEC_DW-1:0];
        end
        // read-only and unmapped words ignore writes
        default: s_d.wr0 = s_d.wr0;
      endcase
    end
  end

  // single state register for the whole channel except the prescaler, which keeps its own
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // one channel instance per copy; output pin only where present
  assign wb_o.ack = s_q.ack;
  assign wb_o.dat = s_q.rdat;
  assign irq_o = s_q.irq;
  assign ch5_match1_event_o = s_q.adc;
  assign ch7_flipflop_output_o = HAS_FF_OUTPUT ? s_q.ff : 1'b0;
endmodule

// [testbench/tec_channel_monitor.sv]
// assertion checker for the timer channel register port and event outputs
`timescale 1ns/10ps
module tec_channel_monitor
  import tec_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h4001_0000,
  parameter bit HAS_FF_OUTPUT = 1'b0,
  parameter bit HAS_ADC_START = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input tec_pkg::tec_wb_req_t wb_i,
  input tec_pkg::tec_wb_rsp_t wb_o,
  input wire logic ch_external_input_i,
  input wire logic internal_pulse_source_i,
  input wire logic debug_halt_i,
  input wire logic idle_mode_i,
  input tec_pkg::tec_irq_t irq_o,
  input wire logic ch5_match1_event_o,
  input wire logic ch7_flipflop_output_o
);
  logic en_q;
  logic [31:0] mask_w;
  logic own_w;
  logic take_w;

  // request decode; address is held until ack, so no history is needed
  assign own_w = (wb_i.adr[31:6] == BASE_ADDR[31:6]);
  assign take_w = wb_i.cyc && wb_i.stb && !wb_o.ack;

  // shadow of the unit enable, rebuilt from taken writes only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      en_q <= 1'b0;
    else if (take_w && wb_i.we && own_w && wb_i.adr[5:0] == OFS_EN && wb_i.sel[0])
      en_q <= wb_i.dat[EN_ENABLE_BIT];
  end

  // bits that may read nonzero at each offset
  always_comb
  begin
    case (wb_i.adr[5:0])
      OFS_EN: mask_w = 32'h0000_00C0;
      OFS_RUN: mask_w = 32'h0000_0005;
      OFS_CR: mask_w = 32'h0000_008B;
      OFS_MOD, OFS_FFCR: mask_w = 32'h0000_00FF;
      OFS_ST, OFS_IM: mask_w = 32'h0000_0007;
      OFS_UC, OFS_RG0, OFS_RG1, OFS_CP0, OFS_CP1: mask_w = 32'h0000_FFFF;
      default: mask_w = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_take;
    take_w;
  endsequence
  sequence s_read_own;
    s_take ##0 (!wb_i.we && own_w);
  endsequence

  a_ack_follows: assert property (s_take |=> wb_o.ack)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property ($rose(wb_o.ack) |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  a_foreign_zero: assert property (s_take ##0 (!wb_i.we && !own_w) |=> wb_o.dat == 32'h0)
    else $error("foreign address read nonzero");
  a_unused_zero: assert property (s_read_own |=> (wb_o.dat & ~mask_w) == 32'h0)
    else $error("unused bits read nonzero");
  a_gated_read: assert property (s_read_own ##0 (!en_q && wb_i.adr[5:0] != OFS_EN)
    |=> wb_o.dat == 32'h0)
    else $error("register readable while unit disabled");
  a_irq_gated: assert property ((!en_q) [*3] |-> irq_o == 5'h00)
    else $error("event while unit disabled");
  a_ovf_single: assert property (irq_o.overflow_interrupt
    |=> (!irq_o.overflow_interrupt) [*8])
    else $error("overflow repeated too soon");
  a_ff_quiet: assert property (!HAS_FF_OUTPUT |-> !ch7_flipflop_output_o)
    else $error("flip-flop pin driven on channel without it");
  a_adc_quiet: assert property (!HAS_ADC_START |-> !ch5_match1_event_o)
    else $error("conversion start on channel without it");
endmodule

bind tec_channel tec_channel_monitor #(
  .BASE_ADDR(BASE_ADDR),
  .HAS_FF_OUTPUT(HAS_FF_OUTPUT),
  .HAS_ADC_START(HAS_ADC_START)
) mon_u (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .wb_i(wb_i),
  .wb_o(wb_o),
  .ch_external_input_i(ch_external_input_i),
  .internal_pulse_source_i(internal_pulse_source_i),
  .debug_halt_i(debug_halt_i),
  .idle_mode_i(idle_mode_i),
  .irq_o(irq_o),
  .ch5_match1_event_o(ch5_match1_event_o),
  .ch7_flipflop_output_o(ch7_flipflop_output_o)
);

// [testbench/tb_top.sv]
// self-checking bench for one timer channel driven over classic wishbone
`timescale 1ns/10ps
module tb_top;
  import tec_pkg::*;
  localparam logic [31:0] BASE = TEC_CH0_BASE;
  logic clk_i;
  logic rst_b;
  logic pulse_q;
  logic halt_q;
  logic idle_q;
  tec_wb_req_t req;
  tec_wb_rsp_t rsp;
  tec_irq_t irq;
  wire [4:0] irq_v = irq;
  int fail_count = 0;
  int samples_checked = 0;
  int match_cnt = 0;
  int cap_cnt = 0;
  logic [31:0] rng_q = 32'h3827;

  tec_channel dut_u (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .wb_i(req),
    .wb_o(rsp),
    .ch_external_input_i(1'b0),
    .internal_pulse_source_i(pulse_q),
    .debug_halt_i(halt_q),
    .idle_mode_i(idle_q),
    .irq_o(irq),
    .ch5_match1_event_o(),
    .ch7_flipflop_output_o()
  );

  // clock generator, 20 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // xorshift source of stimulus values
  function automatic logic [31:0] nxt();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction

  // reset image of each register word
  function automatic logic [31:0] exp_reset(input int i);
    return (i == 3) ? 32'h0000_0040 : (i == 4) ? 32'h0000_00C3 : 32'h0;
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hF, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 50);
    if (n >= 50)
      check("bus ack", 32'h1, 32'h0);
    rd = rsp.dat;
    req <= '0;
  endtask

  task automatic wr(input logic [5:0] o, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, BASE + 32'(o), v, d);
  endtask

  task automatic rd(input logic [5:0] o, output logic [31:0] d);
    bus(1'b0, BASE + 32'(o), 32'h0, d);
  endtask

  // waits for one event bit, counting cycles
  task automatic wait_irq(input int b, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (irq_v[b] !== 1'b1 && n < lim);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // event tallies used by the masking, halt and capture cases
  always @(posedge clk_i)
  begin
    if (irq_v[4] === 1'b1 || irq_v[3] === 1'b1)
      match_cnt++;
    if (irq_v[1] === 1'b1 || irq_v[0] === 1'b1)
      cap_cnt++;
  end

  // limit of 90k cycles; the overflow case alone needs about 66k
  initial
  begin
    #1_800_000;
    fail_count++;
    summarize();
  end

  initial
  begin
    logic [31:0] d;
    logic [31:0] d2;
    logic [31:0] v;
    logic [15:0] per;
    int n;
    int w;
    rst_b = 1'b0;
    req = '0;
    pulse_q = 1'b0;
    halt_q = 1'b0;
    idle_q = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_b <= 1'b1;
    rd(OFS_EN, d);
    check("enable reset", 32'h0, d);
    wr(OFS_RG1, nxt());
    wr(OFS_EN, 32'hFFFF_FFFF);
    rd(OFS_EN, d);
    check("enable bits", 32'h0000_00C0, d);
    for (int i = 1; i < 12; i++)
    begin
      rd(6'(i * 4), d);
      check("reset value", exp_reset(i), d);
    end
    for (int k = 0; k < 4; k++)
    begin
      v = nxt();
      wr(OFS_IM, v);
      rd(OFS_IM, d);
      check("mask bits", v & 32'h7, d);
      wr(OFS_RG1, v);
      rd(OFS_RG1, d);
      check("compare bits", v & 32'hFFFF, d);
      wr(OFS_CR, v & 32'h8B);
      rd(OFS_CR, d);
      check("control bits", v & 32'h8B, d);
      wr(OFS_FFCR, v);
      rd(OFS_FFCR, d);
      check("flip-flop control", 32'hC3 | (v & 32'h3C), d);
    end
    wr(OFS_CR, 32'h0);
    wr(OFS_UC, nxt());
    rd(OFS_UC, d);
    check("snapshot write", 32'h0, d);
    bus(1'b0, BASE + 32'h100, 32'h0, d);
    check("foreign read", 32'h0, d);
    rd(6'h30, d);
    check("unmapped read", 32'h0, d);
    wr(OFS_EN, 32'h40);
    wr(OFS_EN, 32'hC0);
    rd(OFS_RG1, d);
    check("kept setting", v & 32'hFFFF, d);
    // interval with clear on second compare, divide-by-1 source
    per = 16'(nxt() & 32'h3F) + 16'h8;
    wr(OFS_MOD, 32'h49);
    wr(OFS_RG0, 32'(per >> 1));
    wr(OFS_RG1, 32'(per));
    wr(OFS_IM, 32'h7);
    wr(OFS_RUN, 32'h5);
    wait_irq(3, 500, n);
    wait_irq(3, 500, n);
    check("period", 32'(per) + 32'h1, 32'(n));
    @(posedge clk_i);
    halt_q <= 1'b1;
    repeat (2) @(posedge clk_i);
    match_cnt = 0;
    repeat (3 * (per + 1)) @(posedge clk_i);
    check("halted events", 32'h0, 32'(match_cnt));
    halt_q <= 1'b0;
    // system idle with the idle bit clear must freeze the channel too
    idle_q <= 1'b1;
    repeat (2) @(posedge clk_i);
    match_cnt = 0;
    repeat (3 * (per + 1)) @(posedge clk_i);
    check("idle events", 32'h0, 32'(match_cnt));
    idle_q <= 1'b0;
    wr(OFS_RUN, 32'h0);
    rd(OFS_ST, d);
    check("flags", 32'h3, d);
    rd(OFS_ST, d);
    check("flags cleared", 32'h0, d);
    rd(OFS_UC, d);
    repeat (5) @(posedge clk_i);
    rd(OFS_UC, d2);
    check("held snapshot", d, d2);
    check("snapshot range", 32'h1, 32'(d <= 32'(per)));
    wr(OFS_RUN, 32'h5);
    rd(OFS_UC, d);
    check("restart clear", 32'h1, 32'(d < 32'h8));
    // divide-by-4 tap stretches the same period fourfold
    wr(OFS_RUN, 32'h0);
    wr(OFS_MOD, 32'h4A);
    wr(OFS_RUN, 32'h5);
    wait_irq(3, 500, n);
    wait_irq(3, 500, n);
    check("divided period", 32'h4 * (32'(per) + 32'h1), 32'(n));
    wr(OFS_RUN, 32'h0);
    // full wrap with only the overflow event unmasked
    wr(OFS_MOD, 32'h41);
    wr(OFS_RG0, 32'hFFFF);
    wr(OFS_RG1, 32'hFFFF);
    wr(OFS_IM, 32'h4);
    rd(OFS_ST, d);
    match_cnt = 0;
    wr(OFS_RUN, 32'h5);
    wait_irq(2, 70000, n);
    check("wrap time", 32'h1, 32'(n >= 65530 && n <= 65546));
    wr(OFS_RUN, 32'h0);
    rd(OFS_ST, d);
    check("all flags", 32'h7, d);
    check("masked events", 32'h0, 32'(match_cnt));
    // pulse width through both internal pulse edges
    w = 20 + int'(nxt() & 32'hF);
    wr(OFS_MOD, 32'h71);
    cap_cnt = 0;
    wr(OFS_RUN, 32'h5);
    repeat (4) @(posedge clk_i);
    pulse_q <= 1'b1;
    repeat (w) @(posedge clk_i);
    pulse_q <= 1'b0;
    repeat (10) @(posedge clk_i);
    wr(OFS_RUN, 32'h0);
    check("capture events", 32'h2, 32'(cap_cnt));
    rd(OFS_CP0, d);
    rd(OFS_CP1, d2);
    check("pulse width", 32'(w), d2 - d);
    // software capture of the stopped counter overwrites the earlier capture
    wr(OFS_MOD, 32'h31);
    rd(OFS_CP0, d);
    check("software capture", 32'h0, d);
    summarize();
  end
endmodule
